/* rdd_defines.vh */
// Offsets, field layout, reset values and write masks of the rail disable and discharge bank
`ifndef RDD_DEFINES_VH
`define RDD_DEFINES_VH

// Register offsets
`define RDD_OFS_LDO_TWO_CTRL    8'h28
`define RDD_OFS_LDO_THREE_CTRL  8'h29
`define RDD_OFS_DISCH_ONE       8'h40
`define RDD_OFS_DISCH_TWO       8'h41
`define RDD_OFS_DISCH_THREE     8'h42

// Control register layout
`define RDD_RUN_BIT             0
`define RDD_SLEEP_RSV_MSB       5
`define RDD_SLEEP_RSV_LSB       2
`define RDD_LDO_TWO_WMASK       8'h3F
`define RDD_LDO_THREE_WMASK     8'h3D

// Discharge field layout: four fields per register (three in the last), two bits each
`define RDD_FIELD_W             2
`define RDD_FIELDS_PER_REG      4
`define RDD_RAIL_COUNT          11
`define RDD_DISCH_THREE_WMASK   8'h3F

// Discharge codes
`define RDD_DSC_NONE            2'h0
`define RDD_DSC_100_OHM         2'h1
`define RDD_DSC_200_OHM         2'h2
`define RDD_DSC_500_OHM         2'h3

// Factory configuration defaults
`define RDD_RST_LDO_TWO_CTRL    8'h3D
`define RDD_RST_LDO_THREE_CTRL  8'h3D
`define RDD_RST_DISCH_ONE       8'h55
`define RDD_RST_DISCH_TWO       8'h55
`define RDD_RST_DISCH_THREE     8'h15

`endif

/* rdd_dsch_field.v */
// One two-bit discharge selection field that clears itself when its rail turns on
`include "rdd_defines.vh"

module rdd_dsch_field #(
  parameter [1:0] RST_VAL = 2'h1
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Host write
  input  wire       wr_en,
  input  wire [1:0] wr_data,
  // Rail status
  input  wire       rail_en,
  // Field value
  output reg  [1:0] sel_q
);

  reg rail_en_q;

  // Rising edge of the rail enable clears the field; a write in the same cycle loses
  always @(posedge clk) begin
    if (rst) begin
      rail_en_q <= 1'b0;
      sel_q     <= RST_VAL;
    end else begin
      rail_en_q <= rail_en;
      if (rail_en && !rail_en_q) begin
        sel_q <= `RDD_DSC_NONE; // R5
      end else if (wr_en) begin
        sel_q <= wr_data; // R4
      end
    end
  end

endmodule // rdd_dsch_field

/* rdd_regs.v */
// Register bank for forced LDO disable and rail output discharge selection
`include "rdd_defines.vh"

// Behaviour
// R1 - Run bit zero forces second LDO off
// R2 - Third LDO bit 0 disables it
// R3 - Host keeps sleep reserved bits at 1111
// R4 - Two-bit code picks discharge load
// R5 - Rail turning on clears its field
// R6 - Register 40h holds step-down rails one-four
// R7 - Register 41h holds rails five, six, A1, LDO2
// R8 - Register 42h holds LDO3, B1, B2; 7:6 zero
// R9 - Third LDO control decoded at 29h
// R10 - Second LDO control decoded at 28h
// R11 - Reset values are factory build parameters
module rdd_regs #(
  parameter [7:0] RST_LDO_TWO_CTRL   = `RDD_RST_LDO_TWO_CTRL,
  parameter [7:0] RST_LDO_THREE_CTRL = `RDD_RST_LDO_THREE_CTRL,
  parameter [7:0] RST_DISCH_ONE      = `RDD_RST_DISCH_ONE,
  parameter [7:0] RST_DISCH_TWO      = `RDD_RST_DISCH_TWO,
  parameter [7:0] RST_DISCH_THREE    = `RDD_RST_DISCH_THREE
) (
  // Clock and reset
  input  wire        CLOCK,
  input  wire        SYS_RST,
  // Register access from the serial interface
  input  wire [7:0]  REG_ADDR,
  input  wire        REG_WR,
  input  wire [7:0]  REG_WDATA,
  input  wire        REG_RD,
  output reg  [7:0]  REG_RDATA,
  // Enable requests decoded from the control input pins
  input  wire        LDO_TWO_PIN_REQ,
  input  wire        LDO_THREE_PIN_REQ,
  // Enabled state of each rail, index order follows the discharge fields
  input  wire [10:0] RAIL_EN,
  // Regulator enables after the host override
  output reg         LDO_TWO_EN,
  output reg         LDO_THREE_EN,
  // Discharge selections, field i in bits 2i+1:2i
  output wire [21:0] DISCH_SEL
);

  // Full byte compare, used by the write strobe decode; the read mux has its own case
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // Bits of a control register that take a host write; reserved read-only bits drop out
  function [7:0] ctrl_wmask;
    input [7:0] ofs;
    begin
      case (ofs)
        `RDD_OFS_LDO_TWO_CTRL:   ctrl_wmask = `RDD_LDO_TWO_WMASK;
        `RDD_OFS_LDO_THREE_CTRL: ctrl_wmask = `RDD_LDO_THREE_WMASK;
        default:                 ctrl_wmask = 8'h00;
      endcase
    end
  endfunction

  // Reset value of discharge field idx; declared ahead of the generate that calls it
  function [1:0] disch_rst_slice;
    input integer idx;
    reg [23:0] rst_all;
    begin
      rst_all         = {RST_DISCH_THREE & `RDD_DISCH_THREE_WMASK,
                         RST_DISCH_TWO,
                         RST_DISCH_ONE}; // R11
      disch_rst_slice = rst_all[2*idx +: 2];
    end
  endfunction

  // Rail positions in RAIL_EN and DISCH_SEL
  localparam integer RAIL_STEP_DOWN_1  = 0;
  localparam integer RAIL_STEP_DOWN_2  = 1;
  localparam integer RAIL_STEP_DOWN_3  = 2;
  localparam integer RAIL_STEP_DOWN_4  = 3;
  localparam integer RAIL_STEP_DOWN_5  = 4;
  localparam integer RAIL_STEP_DOWN_6  = 5;
  localparam integer RAIL_SWITCH_A_ONE = 6;
  localparam integer RAIL_LDO_TWO      = 7;
  localparam integer RAIL_LDO_THREE    = 8;
  localparam integer RAIL_SWITCH_B_ONE = 9;
  localparam integer RAIL_SWITCH_B_TWO = 10;

  // Register state and decode
  reg  [7:0]  ldo_two_control_q;
  reg  [7:0]  ldo_three_control_q;
  reg  [7:0]  rdata_d;
  wire        ldo_two_wr;
  wire        ldo_three_wr;
  wire        ldo_two_run_bit;
  wire        ldo_three_run_bit;
  wire [2:0]  disch_wr;
  wire [23:0] disch_wdata;
  wire [7:0]  disch_one_rd;
  wire [7:0]  disch_two_rd;
  wire [7:0]  disch_three_rd;

  // Discharge selection of each rail, as held by its field
  wire [1:0]  step_down_1_discharge_sel;
  wire [1:0]  step_down_2_discharge_sel;
  wire [1:0]  step_down_3_discharge_sel;
  wire [1:0]  step_down_4_discharge_sel;
  wire [1:0]  step_down_5_discharge_sel;
  wire [1:0]  step_down_6_discharge_sel;
  wire [1:0]  switch_a_one_discharge_sel;
  wire [1:0]  ldo_two_discharge_sel;
  wire [1:0]  ldo_three_discharge_sel;
  wire [1:0]  switch_b_one_discharge_sel;
  wire [1:0]  switch_b_two_discharge_sel;

  // Named views of the packed field vector
  assign step_down_1_discharge_sel  = DISCH_SEL[2*RAIL_STEP_DOWN_1 +: 2];
  assign step_down_2_discharge_sel  = DISCH_SEL[2*RAIL_STEP_DOWN_2 +: 2];
  assign step_down_3_discharge_sel  = DISCH_SEL[2*RAIL_STEP_DOWN_3 +: 2];
  assign step_down_4_discharge_sel  = DISCH_SEL[2*RAIL_STEP_DOWN_4 +: 2];
  assign step_down_5_discharge_sel  = DISCH_SEL[2*RAIL_STEP_DOWN_5 +: 2];
  assign step_down_6_discharge_sel  = DISCH_SEL[2*RAIL_STEP_DOWN_6 +: 2];
  assign switch_a_one_discharge_sel = DISCH_SEL[2*RAIL_SWITCH_A_ONE +: 2];
  assign ldo_two_discharge_sel      = DISCH_SEL[2*RAIL_LDO_TWO +: 2];
  assign ldo_three_discharge_sel    = DISCH_SEL[2*RAIL_LDO_THREE +: 2];
  assign switch_b_one_discharge_sel = DISCH_SEL[2*RAIL_SWITCH_B_ONE +: 2];
  assign switch_b_two_discharge_sel = DISCH_SEL[2*RAIL_SWITCH_B_TWO +: 2];

  // Write strobes per control register
  assign ldo_two_wr   = REG_WR && hit(REG_ADDR, `RDD_OFS_LDO_TWO_CTRL);   // R10
  assign ldo_three_wr = REG_WR && hit(REG_ADDR, `RDD_OFS_LDO_THREE_CTRL); // R9

  // Write strobes per discharge register
  assign disch_wr[0] = REG_WR && hit(REG_ADDR, `RDD_OFS_DISCH_ONE);   // R6
  assign disch_wr[1] = REG_WR && hit(REG_ADDR, `RDD_OFS_DISCH_TWO);   // R7
  assign disch_wr[2] = REG_WR && hit(REG_ADDR, `RDD_OFS_DISCH_THREE); // R8

  // Every field sees the whole byte; the generate picks its own two bits
  assign disch_wdata = {REG_WDATA, REG_WDATA, REG_WDATA};

  // One field per rail; the fields sit packed so each register is one byte of the vector, six bits for the third
  genvar gi;
  generate
    for (gi = 0; gi < `RDD_RAIL_COUNT; gi = gi + 1) begin : g_field
      rdd_dsch_field #(
        .RST_VAL (disch_rst_slice(gi))
      ) u_field (
        .clk     (CLOCK),
        .rst     (SYS_RST),
        .wr_en   (disch_wr[gi / `RDD_FIELDS_PER_REG]),
        .wr_data (disch_wdata[2*gi+1:2*gi]),
        .rail_en (RAIL_EN[gi]),
        .sel_q   (DISCH_SEL[2*gi+1:2*gi])
      );
    end
  endgenerate

  // Byte views for the read mux; top two bits of the third register read zero
  assign disch_one_rd   = {step_down_4_discharge_sel, step_down_3_discharge_sel,
                           step_down_2_discharge_sel, step_down_1_discharge_sel}; // R6
  assign disch_two_rd   = {ldo_two_discharge_sel, switch_a_one_discharge_sel,
                           step_down_6_discharge_sel, step_down_5_discharge_sel}; // R7
  assign disch_three_rd = {2'h0, switch_b_two_discharge_sel,
                           switch_b_one_discharge_sel, ldo_three_discharge_sel}; // R8

  // Run bits straight out of the control registers
  assign ldo_two_run_bit   = ldo_two_control_q[`RDD_RUN_BIT];   // R1
  assign ldo_three_run_bit = ldo_three_control_q[`RDD_RUN_BIT]; // R2

  // Second LDO control: only writable bits take the write, reserved 7:6 stay zero
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      ldo_two_control_q <= RST_LDO_TWO_CTRL & ctrl_wmask(`RDD_OFS_LDO_TWO_CTRL); // R11
    end else if (ldo_two_wr) begin
      ldo_two_control_q <= REG_WDATA & ctrl_wmask(`RDD_OFS_LDO_TWO_CTRL); // R10
    end
  end

  // Third LDO control: bit 1 is read-only too, so it never holds a one
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      ldo_three_control_q <= RST_LDO_THREE_CTRL & ctrl_wmask(`RDD_OFS_LDO_THREE_CTRL); // R11
    end else if (ldo_three_wr) begin
      ldo_three_control_q <= REG_WDATA & ctrl_wmask(`RDD_OFS_LDO_THREE_CTRL); // R9
    end
  end

  // Run bit overrides whatever the control pins ask for; off by the second edge after a clearing write,
  // and the sleep bits in 5:2 are left to the host since nothing here acts on them
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      LDO_TWO_EN <= 1'b0;
    end else begin
      LDO_TWO_EN <= LDO_TWO_PIN_REQ & ldo_two_run_bit; // R1
    end
  end

  // Same override for the third LDO
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      LDO_THREE_EN <= 1'b0;
    end else begin
      LDO_THREE_EN <= LDO_THREE_PIN_REQ & ldo_three_run_bit; // R2
    end
  end

  // Read mux; unmapped offsets read zero
  always @* begin
    rdata_d = 8'h00;
    case (REG_ADDR)
      `RDD_OFS_LDO_TWO_CTRL:   rdata_d = ldo_two_control_q;   // R10
      `RDD_OFS_LDO_THREE_CTRL: rdata_d = ldo_three_control_q; // R9
      `RDD_OFS_DISCH_ONE:      rdata_d = disch_one_rd;        // R6
      `RDD_OFS_DISCH_TWO:      rdata_d = disch_two_rd;        // R7
      `RDD_OFS_DISCH_THREE:    rdata_d = disch_three_rd;      // R8
      default:                 rdata_d = 8'h00;
    endcase
  end

  // Read data is held until the next read, so the serial shifter may sample late
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= rdata_d;
    end
  end

endmodule // rdd_regs

/* rdd_regs_chk.sv */
// Checker for the rail disable and discharge bank
module rdd_regs_chk (
  // Watched ports
  input wire        CLOCK,
  input wire        SYS_RST,
  input wire [7:0]  REG_ADDR,
  input wire        REG_WR,
  input wire [7:0]  REG_WDATA,
  input wire        REG_RD,
  input wire [7:0]  REG_RDATA,
  input wire        LDO_TWO_PIN_REQ,
  input wire        LDO_THREE_PIN_REQ,
  input wire [10:0] RAIL_EN,
  input wire        LDO_TWO_EN,
  input wire        LDO_THREE_EN,
  input wire [21:0] DISCH_SEL
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // Host writes that clear a run bit
  sequence s_stop2; REG_WR && REG_ADDR == 8'h28 && !REG_WDATA[0]; endsequence
  sequence s_stop3; REG_WR && REG_ADDR == 8'h29 && !REG_WDATA[0]; endsequence
  a_ldo2_forced_off: assert property (s_stop2 |=> ##1 !LDO_TWO_EN) else $error("ldo2 on");
  a_ldo3_forced_off: assert property (s_stop3 |=> ##1 !LDO_THREE_EN) else $error("ldo3 on");
  a_ldo2_pin_off: assert property (!LDO_TWO_PIN_REQ |=> !LDO_TWO_EN) else $error("ldo2 pin");
  a_ldo3_pin_off: assert property (!LDO_THREE_PIN_REQ |=> !LDO_THREE_EN) else $error("ldo3 pin");
  // Every field clears one edge after its rail turns on
  for (genvar i = 0; i < 11; i++) begin : g_rail
    a_rail_clear: assert property ($rose(RAIL_EN[i]) |=> DISCH_SEL[2*i+:2] == 2'h0)
      else $error("field kept");
  end
  a_read_disch: assert property (REG_RD && REG_ADDR == 8'h40
    |=> REG_RDATA == $past(DISCH_SEL[7:0])) else $error("read 40");
  a_write_disch: assert property (REG_WR && REG_ADDR == 8'h41 && RAIL_EN[7:4] == 4'h0
    |=> DISCH_SEL[15:8] == $past(REG_WDATA)) else $error("write 41");
  a_rsv_zero: assert property (REG_RD && REG_ADDR == 8'h42 |=> REG_RDATA[7:6] == 2'h0)
    else $error("rsv 42");
  a_unmapped_zero: assert property (REG_RD
    && !(REG_ADDR inside {8'h28, 8'h29, 8'h40, 8'h41, 8'h42}) |=> REG_RDATA == 8'h00)
    else $error("unmapped");
endmodule // rdd_regs_chk
bind rdd_regs rdd_regs_chk u_rdd_regs_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
  .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .LDO_TWO_PIN_REQ(LDO_TWO_PIN_REQ), .LDO_THREE_PIN_REQ(LDO_THREE_PIN_REQ),
  .RAIL_EN(RAIL_EN), .LDO_TWO_EN(LDO_TWO_EN), .LDO_THREE_EN(LDO_THREE_EN), .DISCH_SEL(DISCH_SEL));

/* rdd_host.sv */
// Host model issuing single-byte register accesses
module rdd_host (
  input  wire        clk,
  output logic [7:0] addr,
  output logic       wr,
  output logic [7:0] wdata,
  output logic       rd,
  input  wire  [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {addr, wr, wdata, rd} = '0;
  // One write strobe; data is scrambled after so a stale byte cannot pass
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = (a == 8'h28 || a == 8'h29) ? d | 8'h3C : d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    wdata = ~wdata;
  endtask
  // One read strobe, data taken once the edge has landed
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask
endmodule // rdd_host

/* rdd_regs_tb.sv */
// Self-checking bench for the rail disable and discharge bank
module rdd_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLOCK = 0, SYS_RST = 1, p2 = 0, p3 = 0, r2 = 1, r3 = 1, wr, rd, e2, e3;
  logic [10:0] rail = '0;
  logic [7:0]  a, d, q, addr, wdata, rdata;
  logic [21:0] dsel;
  integer      seed = 28958, failures = 0, total_checks = 0, cyc = 0, k;
  logic [7:0]  ofs [5] = '{8'h28, 8'h29, 8'h40, 8'h41, 8'h42};
  logic [7:0]  rst_v [5] = '{8'h3D, 8'h3D, 8'h55, 8'h55, 8'h15};
  always #2 CLOCK = ~CLOCK;
  rdd_host u_rdd_host (.clk(CLOCK), .addr(addr), .wr(wr), .wdata(wdata), .rd(rd), .rdata(rdata));
  rdd_regs u_rdd_regs (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .REG_ADDR(addr), .REG_WR(wr),
    .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .LDO_TWO_PIN_REQ(p2),
    .LDO_THREE_PIN_REQ(p3), .RAIL_EN(rail), .LDO_TWO_EN(e2), .LDO_THREE_EN(e3), .DISCH_SEL(dsel));
  // Read-back value after a write, with the host's reserved bits and read-only masks
  function automatic logic [7:0] exp_rd(input logic [7:0] a, input logic [7:0] d);
    case (a)
      8'h28: return (d | 8'h3C) & 8'h3F;
      8'h29: return (d | 8'h3C) & 8'h3D;
      8'h40, 8'h41: return d;
      8'h42: return d & 8'h3F;
      default: return 8'h00;
    endcase
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", what, want, seen);
    end
  endtask
  task automatic test_done;
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(negedge CLOCK);
    SYS_RST = 0;
    for (k = 0; k < 5; k++) begin
      u_rdd_host.rd_reg(ofs[k], q);
      check("reset", q, rst_v[k]);
    end
    // Codes 0..3 in every field first, then random bytes; every sixth access unmapped
    for (k = 0; k < 60; k++) begin
      a = (k % 6 == 5) ? 8'h43 : ofs[k % 5];
      d = (k < 24) ? 8'h55 * (k / 6) : $random(seed);
      p2 = $random(seed);
      p3 = $random(seed);
      if (a == 8'h28) r2 = d[0];
      if (a == 8'h29) r3 = d[0];
      u_rdd_host.wr_reg(a, d);
      u_rdd_host.rd_reg(a, q);
      check("readback", q, exp_rd(a, d));
      check("ldo2 en", e2, p2 & r2);
      check("ldo3 en", e3, p3 & r3);
      if (a[7:4] == 4'h4 && a != 8'h43)
        check("field", 8'({2'h0, dsel} >> (8 * a[1:0])), exp_rd(a, d));
    end
    // Every field nonzero first, so the clear has something to remove
    for (k = 2; k < 5; k++)
      u_rdd_host.wr_reg(ofs[k], 8'hFF);
    check("filled", dsel, 22'h3FFFFF);
    // All rails on at once, then a write while they stay on
    rail = 11'h7FF;
    @(negedge CLOCK);
    check("cleared", dsel, 22'h0);
    u_rdd_host.wr_reg(8'h42, 8'hFF);
    u_rdd_host.rd_reg(8'h42, q);
    check("rewrite", q, 8'h3F);
    // Clear beats a write that lands on the same edge as the rail turning on
    rail = '0;
    u_rdd_host.wr_reg(8'h40, 8'hFF);
    fork
      u_rdd_host.wr_reg(8'h40, 8'hFF);
      begin
        @(negedge CLOCK);
        rail = 11'h001;
      end
    join
    u_rdd_host.rd_reg(8'h40, q);
    check("clear wins", q, 8'hFC);
    test_done();
  end
endmodule // rdd_regs_tb
